// ==== src/ahbm_master.sv ====
// System bus master: core requests in, address/data phases out
//
// Overview of operation
// R1 - Full 32-bit byte address of each transfer driven on the address output.
// R2 - Burst code is SINGLE or INCR only; other codes never appear.
// R3 - Bus request stays high while ownership is still needed.
// R4 - A transfer starts only when grant and ready are both high.
// R5 - Address and control change hands only when ready is high. HTRANS drops to IDLE in the second cycle of a non-OKAY response.
// R6 - While lock is high the arbiter grants no other master.
// R7 - Lock is raised only for the read and write pair of a swap.
// R8 - Protection bit 0 low for fetches, high for data accesses.
// R9 - Protection bit 1 low for user, high for privileged accesses.
// R10 - Protection bit 2 marks bufferable; bit 3 is always low.
// R11 - Read data sampled from the 32-bit read bus when the read completes.
// R12 - Slave stretches with ready low; next data phase waits for ready.
// R13 - Reset is active low and holds the interface in its reset state.
// R14 - Slave answers OKAY during wait states before deciding its response.
// R15 - Response decoded as OKAY, ERROR, RETRY, SPLIT; OKAY with ready completes.
// R16 - ERROR is a two-cycle response telling the master the transfer failed.
// R17 - On RETRY the same transfer is reissued until it completes.
// R18 - On SPLIT the transfer is reissued when next granted the bus.
// R19 - Size code is byte, halfword or word only.
// R20 - Transfer type IDLE, BUSY, NONSEQ, SEQ; SEQ address adds the size.
// R21 - Direction output high for writes, low for reads.
// R22 - ERROR abandons the rest of the burst and reports a bus abort.
`timescale 1ns/100ps
`default_nettype none
module ahbm_master
  import ahbm_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        NRST,
  input  wire ahbm_req_s   CPU_REQ,
  input  wire logic        CPU_VALID,
  output logic             CPU_READY,
  output ahbm_rsp_s        CPU_RSP,
  output logic [31:0]      HADDR,
  output logic [1:0]       HTRANS,
  output logic             HWRITE,
  output logic [2:0]       HSIZE,
  output logic [2:0]       HBURST,
  output logic [3:0]       HPROT,
  output logic [31:0]      HWDATA,
  output logic             HBUSREQ,
  output logic             HLOCK,
  input  wire logic        HGRANT,
  input  wire logic        HREADY,
  input  wire logic [1:0]  HRESP,
  input  wire logic [31:0] HRDATA
);

  function automatic logic [31:0] size_incr(input logic [2:0] size);
    size_incr = 32'h1 << size;
  endfunction : size_incr

  ahbm_req_s          req_q, req_d;
  ahbm_rsp_s          rsp_q, rsp_d;
  logic               ap_q, ap_d;
  logic               seq_q, seq_d;
  logic               dp_q, dp_d;
  logic               lock_q, lock_d;
  logic [31:0]        haddr_q, haddr_d;
  logic [31:0]        dp_addr_q, dp_addr_d;
  logic [31:0]        nxt_q, nxt_d;
  logic [31:0]        hwdata_q, hwdata_d;
  logic [2:0]         burst_q, burst_d;
  logic [BEATS_W-1:0] iss_q, iss_d;
  logic [BEATS_W-1:0] ret_q, ret_d;

  assign CPU_READY = (ret_q == '0);
  assign CPU_RSP   = rsp_q;
  assign HADDR     = haddr_q;                                             // R1
  assign HTRANS    = !ap_q ? TRANS_IDLE : (seq_q ? TRANS_SEQ : TRANS_NSEQ); // R20
  assign HWRITE    = req_q.write;                                         // R21
  assign HSIZE     = req_q.size;                                          // R19
  assign HBURST    = burst_q;                                             // R2
  assign HPROT     = {PROT_NOCACHE, req_q.bufable, req_q.priv, !req_q.fetch}; // R10 R9 R8
  assign HWDATA    = hwdata_q;
  assign HBUSREQ   = (ret_q != '0) || lock_q;                             // R3 R6
  assign HLOCK     = lock_q;                                              // R6 R7

  always_comb begin
    logic [BEATS_W-1:0] iss;
    logic [BEATS_W-1:0] ret;
    logic               fail;
    iss       = iss_q;
    ret       = ret_q;
    fail      = 1'b0;
    req_d     = req_q;
    ap_d      = ap_q;
    seq_d     = seq_q;
    dp_d      = dp_q;
    lock_d    = lock_q;
    haddr_d   = haddr_q;
    dp_addr_d = dp_addr_q;
    nxt_d     = nxt_q;
    hwdata_d  = hwdata_q;
    burst_d   = burst_q;
    rsp_d     = '{done: 1'b0, abort: 1'b0, rdata: rsp_q.rdata};
    if (CPU_VALID && CPU_READY) begin
      req_d = CPU_REQ;
      if (CPU_REQ.write || CPU_REQ.beats == '0) begin
        req_d.beats = BEATS_W'(1);
      end
      iss    = req_d.beats;
      ret    = req_d.beats;
      nxt_d  = CPU_REQ.addr;
      lock_d = CPU_REQ.lock;                                              // R7
    end else if (HREADY) begin                                            // R12
      if (dp_q) begin
        if (HRESP == RESP_OKAY) begin                                     // R15
          rsp_d.done = 1'b1;
          if (!req_q.write) begin
            rsp_d.rdata = HRDATA;                                         // R11
          end
          ret = ret_q - BEATS_W'(1);
          if (ret == '0 && req_q.lock_end) begin
            lock_d = 1'b0;                                                // R7
          end
        end else if (HRESP == RESP_ERROR) begin                           // R16
          fail        = 1'b1;
          rsp_d.abort = 1'b1;                                             // R22
          iss         = '0;
          ret         = '0;
          lock_d      = 1'b0;
        end
      end
      // Address phase moves into the data phase
      dp_d      = ap_q;                                                   // R5
      dp_addr_d = haddr_q;
      if (ap_q) begin
        hwdata_d = req_q.wdata;
      end
      if (iss != '0 && HGRANT && !fail) begin                             // R4 R17 R18
        ap_d    = 1'b1;
        seq_d   = ap_q;
        haddr_d = nxt_q;
        nxt_d   = nxt_q + size_incr(req_q.size);                          // R20
        if (!ap_q) begin
          burst_d = (iss > BEATS_W'(1)) ? BURST_INCR : BURST_SINGLE;      // R2
        end
        iss = iss - BEATS_W'(1);
      end else begin
        ap_d  = 1'b0;
        seq_d = 1'b0;
      end
    end else if (dp_q && HRESP != RESP_OKAY) begin                        // R14
      // First response cycle: cancel pending address, rewind to failed beat
      ap_d  = 1'b0;
      seq_d = 1'b0;
      nxt_d = dp_addr_q;                                                  // R17 R18
      iss   = ret_q;
    end
    iss_d = iss;
    ret_d = ret;
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin                                                      // R13
      req_q     <= '0;
      rsp_q     <= '0;
      ap_q      <= 1'b0;
      seq_q     <= 1'b0;
      dp_q      <= 1'b0;
      lock_q    <= 1'b0;
      haddr_q   <= '0;
      dp_addr_q <= '0;
      nxt_q     <= '0;
      hwdata_q  <= '0;
      burst_q   <= BURST_SINGLE;
      iss_q     <= '0;
      ret_q     <= '0;
    end else begin
      req_q     <= req_d;
      rsp_q     <= rsp_d;
      ap_q      <= ap_d;
      seq_q     <= seq_d;
      dp_q      <= dp_d;
      lock_q    <= lock_d;
      haddr_q   <= haddr_d;
      dp_addr_q <= dp_addr_d;
      nxt_q     <= nxt_d;
      hwdata_q  <= hwdata_d;
      burst_q   <= burst_d;
      iss_q     <= iss_d;
      ret_q     <= ret_d;
    end
  end

  a_burst_legal: assert property (@(posedge CLOCK) disable iff (!NRST) // R2
    HBURST == BURST_SINGLE || HBURST == BURST_INCR)
    else $error("illegal burst code");

  a_size_legal: assert property (@(posedge CLOCK) disable iff (!NRST) // R19
    ap_q |-> (HSIZE == SIZE_BYTE || HSIZE == SIZE_HALF || HSIZE == SIZE_WORD))
    else $error("illegal size code");

  a_busreq_held: assert property (@(posedge CLOCK) disable iff (!NRST) // R3
    (ret_q != '0) |-> HBUSREQ)
    else $error("bus request dropped while work pending");

  a_start_granted: assert property (@(posedge CLOCK) disable iff (!NRST) // R4
    (HTRANS == TRANS_NSEQ && !$past(ap_q)) |-> $past(HGRANT && HREADY))
    else $error("transfer started without grant and ready");

  a_addr_stable: assert property (@(posedge CLOCK) disable iff (!NRST) // R5
    (ap_q && !HREADY && !(dp_q && HRESP != RESP_OKAY)) |=> ap_q && $stable(HADDR))
    else $error("address changed while ready low");

  a_lock_release: assert property (@(posedge CLOCK) disable iff (!NRST) // R7
    (dp_q && HREADY && HRESP == RESP_OKAY && ret_q == BEATS_W'(1) && req_q.lock_end)
    |=> !HLOCK)
    else $error("lock held past swap pair");

  a_prot_map: assert property (@(posedge CLOCK) disable iff (!NRST) // R8 R9 R10
    ap_q |-> (HPROT[3] == PROT_NOCACHE && HPROT[2] == req_q.bufable
              && HPROT[1] == req_q.priv && HPROT[0] == !req_q.fetch))
    else $error("protection bits wrong");

  a_seq_addr: assert property (@(posedge CLOCK) disable iff (!NRST) // R20
    (HTRANS == TRANS_SEQ && !$stable(HADDR)) |-> HADDR == $past(HADDR) + size_incr(HSIZE))
    else $error("sequential address not incremented by size");

  a_resp_idle: assert property (@(posedge CLOCK) disable iff (!NRST) // R17
    (dp_q && !HREADY && HRESP != RESP_OKAY) |=> HTRANS == TRANS_IDLE)
    else $error("address not cancelled on two-cycle response");

  a_retry_again: assert property (@(posedge CLOCK) disable iff (!NRST) // R18
    (dp_q && HREADY && (HRESP == RESP_RETRY || HRESP == RESP_SPLIT))
    |=> HBUSREQ && !CPU_RSP.done && !CPU_READY)
    else $error("retried transfer dropped");

  a_err_abort: assert property (@(posedge CLOCK) disable iff (!NRST) // R22
    (dp_q && HREADY && HRESP == RESP_ERROR) |=> CPU_RSP.abort && CPU_READY ##1 !ap_q)
    else $error("error did not abort request");

  // Bus side checks
  a_trans_nobusy: assert property (@(posedge CLOCK) disable iff (!NRST) // R20
    HTRANS != TRANS_BUSY)
    else $error("busy transfer type driven");

  a_addr_issue: assert property (@(posedge CLOCK) disable iff (!NRST) // R1
    (HTRANS == TRANS_NSEQ && !$past(ap_q)) |-> HADDR == $past(nxt_q))
    else $error("first beat address not the pending address");

  a_write_single: assert property (@(posedge CLOCK) disable iff (!NRST) // R2
    (HTRANS == TRANS_NSEQ && HWRITE) |-> HBURST == BURST_SINGLE)
    else $error("write issued as a burst");

  a_lock_rise: assert property (@(posedge CLOCK) disable iff (!NRST) // R7
    $rose(HLOCK) |-> $past(CPU_VALID && CPU_READY && CPU_REQ.lock))
    else $error("lock raised without a swap request");

  a_lock_busreq: assert property (@(posedge CLOCK) disable iff (!NRST) // R6
    HLOCK |-> HBUSREQ)
    else $error("bus request dropped while locked");

  a_ctrl_hold: assert property (@(posedge CLOCK) disable iff (!NRST) // R5
    (dp_q && !HREADY) |=> $stable(HWRITE) && $stable(HSIZE) && $stable(HPROT))
    else $error("control changed while ready low");

  a_write_data: assert property (@(posedge CLOCK) disable iff (!NRST) // R21
    (ap_q && HREADY && HWRITE) |=> HWDATA == $past(req_q.wdata))
    else $error("write data not presented in data phase");

  a_wait_hold: assert property (@(posedge CLOCK) disable iff (!NRST) // R12
    (dp_q && !HREADY && HRESP == RESP_OKAY) |=> dp_q && $stable(ret_q) && !CPU_RSP.done)
    else $error("data phase advanced while ready low");

  a_reset_idle: assert property (@(posedge CLOCK) // R13
    !NRST |=> HTRANS == TRANS_IDLE && !HBUSREQ && !HLOCK && CPU_READY)
    else $error("interface not idle after reset");

  // Core side checks
  a_read_capture: assert property (@(posedge CLOCK) disable iff (!NRST) // R11
    (dp_q && HREADY && HRESP == RESP_OKAY && !req_q.write)
    |=> CPU_RSP.done && CPU_RSP.rdata == $past(HRDATA))
    else $error("read data not captured on completion");

  a_okay_retire: assert property (@(posedge CLOCK) disable iff (!NRST) // R15
    (dp_q && HREADY && HRESP == RESP_OKAY) |=> CPU_RSP.done && !CPU_RSP.abort)
    else $error("completed beat not reported");

  a_retry_rewind: assert property (@(posedge CLOCK) disable iff (!NRST) // R17 R18
    (dp_q && !HREADY && HRESP != RESP_OKAY) |=> nxt_q == $past(dp_addr_q) && iss_q == ret_q)
    else $error("failed beat not rewound");

  a_abort_alone: assert property (@(posedge CLOCK) disable iff (!NRST) // R22
    CPU_RSP.abort |-> !CPU_RSP.done)
    else $error("abort reported with a completed beat");

  // Scenario coverage
  c_burst_seq: cover property (@(posedge CLOCK) disable iff (!NRST)
    HTRANS == TRANS_SEQ && HREADY);
  c_retry: cover property (@(posedge CLOCK) disable iff (!NRST)
    dp_q && HREADY && HRESP == RESP_RETRY);
  c_error: cover property (@(posedge CLOCK) disable iff (!NRST)
    CPU_RSP.abort);
  c_locked: cover property (@(posedge CLOCK) disable iff (!NRST)
    HLOCK && ap_q && HWRITE);
  c_split: cover property (@(posedge CLOCK) disable iff (!NRST)
    dp_q && HREADY && HRESP == RESP_SPLIT);

endmodule : ahbm_master
`default_nettype wire

// ==== src/ahbm_pkg.sv ====
// Shared encodings and carriers of the system bus master interface
`default_nettype none
package ahbm_pkg;
  localparam int          BEATS_W     = 8;
  localparam logic [1:0]  TRANS_IDLE  = 2'h0;
  localparam logic [1:0]  TRANS_BUSY  = 2'h1;
  localparam logic [1:0]  TRANS_NSEQ  = 2'h2;
  localparam logic [1:0]  TRANS_SEQ   = 2'h3;
  localparam logic [2:0]  BURST_SINGLE = 3'h0;
  localparam logic [2:0]  BURST_INCR  = 3'h1;
  localparam logic [2:0]  SIZE_BYTE   = 3'h0;
  localparam logic [2:0]  SIZE_HALF   = 3'h1;
  localparam logic [2:0]  SIZE_WORD   = 3'h2;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_ERROR  = 2'h1;
  localparam logic [1:0]  RESP_RETRY  = 2'h2;
  localparam logic [1:0]  RESP_SPLIT  = 2'h3;
  localparam logic        PROT_NOCACHE = 1'b0;

  typedef struct packed {
    logic [31:0]        addr;
    logic [31:0]        wdata;
    logic               write;
    logic [2:0]         size;
    logic [BEATS_W-1:0] beats;
    logic               fetch;
    logic               priv;
    logic               bufable;
    logic               lock;
    logic               lock_end;
  } ahbm_req_s;

  typedef struct packed {
    logic               done;
    logic               abort;
    logic [31:0]        rdata;
  } ahbm_rsp_s;
endpackage : ahbm_pkg
`default_nettype wire

// ==== test/ahbm_bus_model.sv ====
// Behavioural arbiter and slave facing the bus master
`timescale 1ns/100ps
`default_nettype none
module ahbm_bus_model
  import ahbm_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        NRST,
  input  wire logic        HBUSREQ,
  input  wire logic [1:0]  HTRANS,
  input  wire logic [31:0] HADDR,
  input  wire logic        INJECT,
  input  wire logic [1:0]  FAIL_CODE,
  input  wire logic [1:0]  WAITS,
  output logic             HGRANT,
  output logic             HREADY,
  output logic [1:0]       HRESP,
  output logic [31:0]      HRDATA
);
  logic        ph_q, err_q;
  logic [1:0]  cnt_q, bad_q, pend_q;
  logic [31:0] a_q;
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      {ph_q, err_q, cnt_q, bad_q, pend_q, a_q, HGRANT} <= '0;
    end else begin
      HGRANT <= HBUSREQ;
      if (INJECT) pend_q <= FAIL_CODE;
      if (HREADY) begin
        ph_q  <= HTRANS[1];
        a_q   <= HADDR;
        cnt_q <= WAITS;
        err_q <= 1'b0;
        bad_q <= HTRANS[1] ? pend_q : RESP_OKAY;
        if (HTRANS[1]) pend_q <= RESP_OKAY;
      end else if (cnt_q != 2'h0) begin
        cnt_q <= cnt_q - 2'h1;
      end else begin
        err_q <= 1'b1;
      end
    end
  end
  always_comb begin
    HREADY = 1'b1;
    HRESP  = RESP_OKAY;
    HRDATA = a_q + 32'h1;
    if (ph_q) begin
      if (cnt_q != 2'h0) begin
        HREADY = 1'b0;
      end else if (bad_q != RESP_OKAY) begin
        HRESP  = bad_q;
        HREADY = err_q;
      end else begin
        HRDATA = ~a_q;
      end
    end
  end
endmodule : ahbm_bus_model
`default_nettype wire

// ==== test/test_ahbm_master.sv ====
// Self-checking bench of the bus master
`timescale 1ns/100ps
`default_nettype none
module test_ahbm_master import ahbm_pkg::*;;
  typedef struct packed {
    ahbm_req_s  r;
    logic [3:0] prot;
    logic [2:0] burst;
    logic [3:0] n;
  } ahbm_row_s;
  logic        clock, nrst, valid, ready, hwrite, hbusreq, hlock, hgrant, hready, inject, wph;
  logic [1:0]  htrans, hresp, fail_code, waits;
  logic [2:0]  hsize, hburst, exp_burst;
  logic [3:0]  hprot, exp_prot;
  logic [31:0] haddr, hwdata, hrdata, last;
  ahbm_req_s   req, cur;
  ahbm_rsp_s   rsp;
  ahbm_row_s   rows [5];
  int          failures = 0, num_checks = 0, nseq, nd, na, k;

  ahbm_master uut (.CLOCK(clock), .NRST(nrst), .CPU_REQ(req), .CPU_VALID(valid),
    .CPU_READY(ready), .CPU_RSP(rsp), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HBURST(hburst), .HPROT(hprot), .HWDATA(hwdata), .HBUSREQ(hbusreq),
    .HLOCK(hlock), .HGRANT(hgrant), .HREADY(hready), .HRESP(hresp), .HRDATA(hrdata));
  ahbm_bus_model bus (.CLOCK(clock), .NRST(nrst), .HBUSREQ(hbusreq), .HTRANS(htrans),
    .HADDR(haddr), .INJECT(inject), .FAIL_CODE(fail_code), .WAITS(waits), .HGRANT(hgrant),
    .HREADY(hready), .HRESP(hresp), .HRDATA(hrdata));

  function automatic ahbm_req_s rq(logic [31:0] a, int w, logic [2:0] s,
                                   int b, int f, p, bf, lk, le);
    rq = '{a, ~a, 1'(w), s, BEATS_W'(b), 1'(f), 1'(p), 1'(bf), 1'(lk), 1'(le)};
  endfunction : rq

  task automatic check(input string name, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  task automatic issue(input ahbm_req_s r, input logic [3:0] pr, input logic [2:0] bu);
    cur = r;
    exp_prot = pr;
    exp_burst = bu;
    nseq = 0;
    req = r;
    valid = 1'b1;
    @(posedge clock);
    #1 valid = 1'b0;
  endtask : issue

  task automatic run(input ahbm_req_s r, input logic [3:0] pr, input logic [2:0] bu);
    int i;
    nd = 0;
    na = 0;
    issue(r, pr, bu);
    for (i = 0; i < 300; i++) begin
      @(posedge clock);
      #1;
      if (rsp.done === 1'b1) nd++;
      if (rsp.abort === 1'b1) na++;
      if (ready === 1'b1) break;
    end
    if (i == 300) begin
      failures++;
      results();
    end
  endtask : run

  task automatic inject_fail(input logic [1:0] c);
    fail_code = c;
    inject = 1'b1;
    @(posedge clock);
    #1 inject = 1'b0;
  endtask : inject_fail

  // Bus monitor on each accepted address phase
  always @(posedge clock) begin
    if (nrst && hready) begin
      if (wph) check("wdata", hwdata, cur.wdata);
      wph = htrans[1] && hwrite;
    end
    if (nrst && hready && htrans[1]) begin
      if (htrans == TRANS_SEQ) begin
        check("seq addr", haddr, last + (32'h1 << hsize));
      end else begin
        if (nseq == 0) check("addr", haddr, cur.addr);
        check("burst", 32'(hburst), 32'(exp_burst));
        nseq++;
      end
      check("prot", 32'(hprot), 32'(exp_prot));
      check("size", 32'(hsize), 32'(cur.size));
      check("dir", 32'(hwrite), 32'(cur.write));
      check("lock", 32'(hlock), 32'(cur.lock));
      last = haddr;
    end
  end

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    {nrst, valid, inject, wph, fail_code, waits, req, cur} = '0;
    rows[0] = '{rq(32'h1000, 0, SIZE_WORD, 1, 1, 0, 0, 0, 0), 4'h0, BURST_SINGLE, 4'h1};
    rows[1] = '{rq(32'h2000, 0, SIZE_WORD, 4, 0, 1, 0, 0, 0), 4'h3, BURST_INCR, 4'h4};
    rows[2] = '{rq(32'h3002, 1, SIZE_HALF, 3, 0, 0, 1, 0, 0), 4'h5, BURST_SINGLE, 4'h1};
    rows[3] = '{rq(32'h4001, 0, SIZE_BYTE, 3, 0, 0, 1, 0, 0), 4'h5, BURST_INCR, 4'h3};
    rows[4] = '{rq(32'h5003, 1, SIZE_BYTE, 0, 0, 1, 0, 0, 0), 4'h3, BURST_SINGLE, 4'h1};
    repeat (12) @(posedge clock);
    #1 nrst = 1'b1;
    for (k = 0; k < 5; k++) begin
      waits = 2'(k % 3);
      run(rows[k].r, rows[k].prot, rows[k].burst);
      check("beats", 32'(nd), 32'(rows[k].n));
      if (!rows[k].r.write) check("rdata", rsp.rdata,
        ~(rows[k].r.addr + ((32'(rows[k].n) - 32'h1) << rows[k].r.size)));
      $display("test %0d done", k);
    end
    for (k = 0; k < 2; k++) begin
      inject_fail(k == 0 ? RESP_RETRY : RESP_SPLIT);
      run(rq(32'h6000, 0, SIZE_WORD, 1, 0, 0, 0, 0, 0), 4'h1, BURST_SINGLE);
      check("reissue", 32'(nseq), 32'h2);
      check("reissue done", 32'(nd), 32'h1);
      check("reissue data", rsp.rdata, ~32'h6000);
      $display("retry test %0d done", k);
    end
    inject_fail(RESP_ERROR);
    run(rq(32'h7000, 0, SIZE_WORD, 4, 0, 0, 0, 0, 0), 4'h1, BURST_INCR);
    check("abort", 32'(na), 32'h1);
    check("dropped", 32'(nseq + nd), 32'h1);
    $display("error test done");
    run(rq(32'h8000, 0, SIZE_WORD, 1, 0, 1, 0, 1, 0), 4'h3, BURST_SINGLE);
    run(rq(32'h8000, 1, SIZE_WORD, 1, 0, 1, 0, 1, 1), 4'h3, BURST_SINGLE);
    check("unlock", 32'(hlock), 32'h0);
    $display("swap test done");
    waits = 2'h3;
    issue(rq(32'h9000, 0, SIZE_WORD, 4, 0, 0, 0, 0, 0), 4'h1, BURST_INCR);
    repeat (3) @(posedge clock);
    #1 nrst = 1'b0;
    @(posedge clock);
    #1;
    check("reset trans", 32'(htrans), 32'(TRANS_IDLE));
    check("reset req", 32'(hbusreq), 32'h0);
    check("reset ready", 32'(ready), 32'h1);
    nrst = 1'b1;
    $display("reset test done");
    results();
  end
endmodule : test_ahbm_master
`default_nettype wire
